// ===== pkg/dlct_pkg.sv
// shared constants and types for the dual counter/timer block
package dlct_pkg;

	// register byte addresses
	localparam logic [7:0] DLCT_OFF_T0_LOW = 8'h00;
	localparam logic [7:0] DLCT_OFF_T0_HIGH = 8'h04;
	localparam logic [7:0] DLCT_OFF_T1_LOW = 8'h08;
	localparam logic [7:0] DLCT_OFF_T1_HIGH = 8'h0C;
	localparam logic [7:0] DLCT_OFF_CTRL = 8'h10;
	localparam logic [7:0] DLCT_OFF_MODE = 8'h14;
	localparam logic [7:0] DLCT_OFF_CLKCTL = 8'h18;
	localparam logic [7:0] DLCT_OFF_IRQCFG = 8'h1C;
	localparam logic [7:0] DLCT_OFF_IRQEN = 8'h20;

	// control register: run bit 4 and flag bit 5 for timer 0, plus 2 per timer
	localparam int DLCT_CTRL_RUN_BIT = 4;
	localparam int DLCT_CTRL_FLAG_BIT = 5;
	localparam int DLCT_CTRL_STRIDE = 2;
	// mode register: one nibble per timer
	localparam int DLCT_MODE_SEL_LSB = 0;
	localparam int DLCT_MODE_CT_BIT = 2;
	localparam int DLCT_MODE_GATE_BIT = 3;
	localparam int DLCT_MODE_STRIDE = 4;
	// clock control: scale bits 1:0, system clock select bit 3 (+1 per timer)
	localparam int DLCT_CLK_SCALE_LSB = 0;
	localparam int DLCT_CLK_SYS_BIT = 3;
	// gate polarity bit 3 (+4 per timer), interrupt enable bit 1 (+2 per timer)
	localparam int DLCT_POL_BIT = 3;
	localparam int DLCT_POL_STRIDE = 4;
	localparam int DLCT_IRQEN_BIT = 1;
	localparam int DLCT_IRQEN_STRIDE = 2;

	localparam logic [7:0] DLCT_RST_BYTE = 8'h00;
	localparam logic [5:0] DLCT_RST_PRE = 6'h00;

	// prescaler: divide ratios for scale codes 0..3, shared wrap of 48
	localparam logic [5:0] DLCT_PRE_DIV0 = 6'h0C;
	localparam logic [5:0] DLCT_PRE_DIV1 = 6'h04;
	localparam logic [5:0] DLCT_PRE_DIV2 = 6'h30;
	localparam logic [5:0] DLCT_PRE_DIV3 = 6'h08;
	localparam logic [5:0] DLCT_PRE_LAST = 6'h2F;

	localparam logic [1:0] DLCT_RESP_OKAY = 2'h0;
	localparam logic [1:0] DLCT_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DLCT_MODE_13 = 2'b00,
		DLCT_MODE_16 = 2'b01,
		DLCT_MODE_8R = 2'b10,
		DLCT_MODE_HOLD = 2'b11
	} dlct_mode_t;

endpackage

// ===== rtl/dlct_timer.sv
// one counter/timer channel: event pin sampling, enable and count
`timescale 1ns/1ns
`default_nettype none
module dlct_timer import dlct_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic tick_pre,
	input wire dlct_mode_t mode,
	input wire logic ct_sel,
	input wire logic sys_sel,
	input wire logic gate_bit,
	input wire logic gate_act,
	input wire logic run,
	input wire logic event_pin,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	output logic [7:0] count_lo,
	output logic [7:0] count_hi,
	output logic ovf
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic [7:0] lo;
		logic [7:0] hi;
	} dlct_tmr_st_t;

	dlct_tmr_st_t s_r;
	dlct_tmr_st_t s_nxt;
	logic fall;
	logic tick;
	logic en;
	logic [12:0] c13;
	logic [15:0] c16;

	always_comb begin
		s_nxt = s_r;
		ovf = 1'b0;
		s_nxt.sync1 = event_pin;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev = s_r.sync2;
		fall = s_r.prev & ~s_r.sync2;
		tick = ct_sel ? fall : (sys_sel ? 1'b1 : tick_pre);
		en = run & (~gate_bit | gate_act) & tick;
		c13 = {s_r.hi, s_r.lo[4:0]} + 13'h0001;
		c16 = {s_r.hi, s_r.lo} + 16'h0001;
		if (en) begin
			unique case (mode)
				DLCT_MODE_13: begin
					// high byte plus five low bits
					s_nxt.hi = c13[12:5];
					s_nxt.lo[4:0] = c13[4:0];
					ovf = &{s_r.hi, s_r.lo[4:0]};
				end
				DLCT_MODE_16: begin
					s_nxt.hi = c16[15:8];
					s_nxt.lo = c16[7:0];
					ovf = &{s_r.hi, s_r.lo};
				end
				DLCT_MODE_8R: begin
					if (&s_r.lo) begin
						s_nxt.lo = s_r.hi;
						ovf = 1'b1;
					end else begin
						s_nxt.lo = s_r.lo + 8'h01;
					end
				end
				DLCT_MODE_HOLD: begin
					s_nxt.lo = s_r.lo;
				end
			endcase
		end
		if (wr_lo) begin
			s_nxt.lo = wdata;
		end
		if (wr_hi) begin
			s_nxt.hi = wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign count_lo = s_r.lo;
	assign count_hi = s_r.hi;

endmodule
`default_nettype wire

// ===== rtl/dlct_top.sv
// dual counter/timer with an AXI4-Lite register slave
// Behaviour
// - each timer has a 16-bit count read and written as low and high bytes
// - each timer takes its mode from its own bits of the shared mode register
// - 13-bit mode: high byte holds top eight bits, low bits 4..0 the rest
// - 13-bit wrap sets the timer's overflow flag and requests an interrupt
// - counter select set: count falling edges of the timer's event pin
// - counter select clear: system clock or prescaled clock per clock-source bit
// - event rates up to a quarter of the system clock are counted
// - count only when run set and gate off or gate input active
// - timer 0 gated by irq input 0, timer 1 by input 1, polarity programmable
// - setting run leaves the count registers untouched
// - 16-bit mode works like 13-bit mode with all sixteen bits
// - auto-reload: low byte counts, wrap sets flag and reloads from high byte
// - timer 1 offers the same modes with its own bits
// - clock source is event pin, system clock or a prescaled clock
// - overflow request passes only when that timer's enable bit is set
// - overflow flag stays set until software or interrupt entry clears it
//
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module dlct_top import dlct_pkg::*; (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic T0_EVENT_PIN,
	input wire logic T1_EVENT_PIN,
	input wire logic EXT_IRQ0_INPUT,
	input wire logic EXT_IRQ1_INPUT,
	input wire logic T0_IRQ_ACK,
	input wire logic T1_IRQ_ACK,
	output logic T0_IRQ_REQ,
	output logic T1_IRQ_REQ
);

	localparam int NT = 2;

	typedef struct packed {
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [7:0] wdata;
		logic wstb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [1:0] run;
		logic [1:0] flag;
		logic [7:0] mode_reg;
		logic [7:0] clk_reg;
		logic [7:0] cfg_reg;
		logic [7:0] irq_en_reg;
		logic [5:0] pre_cnt;
	} dlct_st_t;

	dlct_st_t s_r;
	dlct_st_t s_nxt;

	logic wr_fire;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_data;
	logic tick_pre;
	logic [5:0] pre_div;
	logic [1:0] scale;
	logic [NT-1:0] ack;
	logic [NT-1:0] pins;
	logic [NT-1:0] gate_in;
	logic [NT-1:0] ovf;
	logic [NT-1:0] wr_lo;
	logic [NT-1:0] wr_hi;
	logic [7:0] cnt_lo [NT];
	logic [7:0] cnt_hi [NT];
	logic [7:0] ctrl_view;

	assign ack = {T1_IRQ_ACK, T0_IRQ_ACK};
	assign pins = {T1_EVENT_PIN, T0_EVENT_PIN};
	assign gate_in = {EXT_IRQ1_INPUT, EXT_IRQ0_INPUT};

	// bus handshakes
	assign S_AXI_AWREADY = ~s_r.aw_got & ~s_r.bvalid;
	assign S_AXI_WREADY = ~s_r.w_got & ~s_r.bvalid;
	assign S_AXI_ARREADY = ~s_r.rvalid;
	assign wr_fire = s_r.aw_got & s_r.w_got & ~s_r.bvalid;

	// prescaler tick for the chosen divide ratio
	assign scale = s_r.clk_reg[DLCT_CLK_SCALE_LSB +: 2];
	always_comb begin
		unique case (scale)
			2'h0: pre_div = DLCT_PRE_DIV0;
			2'h1: pre_div = DLCT_PRE_DIV1;
			2'h2: pre_div = DLCT_PRE_DIV2;
			2'h3: pre_div = DLCT_PRE_DIV3;
		endcase
		tick_pre = (s_r.pre_cnt % pre_div) == (pre_div - 6'h01);
	end

	// control view: reserved low bits read zero
	always_comb begin
		ctrl_view = DLCT_RST_BYTE;
		for (int i = 0; i < NT; i++) begin
			ctrl_view[DLCT_CTRL_RUN_BIT + DLCT_CTRL_STRIDE * i] = s_r.run[i];
			ctrl_view[DLCT_CTRL_FLAG_BIT + DLCT_CTRL_STRIDE * i] = s_r.flag[i];
		end
	end

	// write address decode
	always_comb begin
		unique case (s_r.awaddr)
			DLCT_OFF_T0_LOW, DLCT_OFF_T0_HIGH,
			DLCT_OFF_T1_LOW, DLCT_OFF_T1_HIGH,
			DLCT_OFF_CTRL, DLCT_OFF_MODE,
			DLCT_OFF_CLKCTL, DLCT_OFF_IRQCFG,
			DLCT_OFF_IRQEN: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		wr_lo = '0;
		wr_hi = '0;
		if (wr_fire && s_r.wstb) begin
			wr_lo[0] = s_r.awaddr == DLCT_OFF_T0_LOW;
			wr_hi[0] = s_r.awaddr == DLCT_OFF_T0_HIGH;
			wr_lo[1] = s_r.awaddr == DLCT_OFF_T1_LOW;
			wr_hi[1] = s_r.awaddr == DLCT_OFF_T1_HIGH;
		end
	end

	// read mux
	always_comb begin
		rd_hit = 1'b1;
		unique case (S_AXI_ARADDR)
			DLCT_OFF_T0_LOW: rd_data = cnt_lo[0];
			DLCT_OFF_T0_HIGH: rd_data = cnt_hi[0];
			DLCT_OFF_T1_LOW: rd_data = cnt_lo[1];
			DLCT_OFF_T1_HIGH: rd_data = cnt_hi[1];
			DLCT_OFF_CTRL: rd_data = ctrl_view;
			DLCT_OFF_MODE: rd_data = s_r.mode_reg;
			DLCT_OFF_CLKCTL: rd_data = s_r.clk_reg;
			DLCT_OFF_IRQCFG: rd_data = s_r.cfg_reg;
			DLCT_OFF_IRQEN: rd_data = s_r.irq_en_reg;
			default: begin
				rd_data = DLCT_RST_BYTE;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.pre_cnt = (s_r.pre_cnt == DLCT_PRE_LAST) ? DLCT_RST_PRE :
			s_r.pre_cnt + 6'h01;

		// write channel capture, either order
		if (S_AXI_AWVALID && S_AXI_AWREADY) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && S_AXI_WREADY) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = S_AXI_WDATA[7:0];
			s_nxt.wstb = S_AXI_WSTRB[0];
		end
		if (s_r.bvalid && S_AXI_BREADY) begin
			s_nxt.bvalid = 1'b0;
		end

		if (wr_fire) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wr_hit ? DLCT_RESP_OKAY : DLCT_RESP_SLVERR;
			if (s_r.wstb) begin
				unique case (s_r.awaddr)
					DLCT_OFF_CTRL: begin
						for (int i = 0; i < NT; i++) begin
							s_nxt.run[i] =
								s_r.wdata[DLCT_CTRL_RUN_BIT + DLCT_CTRL_STRIDE * i];
							s_nxt.flag[i] =
								s_r.wdata[DLCT_CTRL_FLAG_BIT + DLCT_CTRL_STRIDE * i];
						end
					end
					DLCT_OFF_MODE: s_nxt.mode_reg = s_r.wdata;
					DLCT_OFF_CLKCTL: s_nxt.clk_reg = s_r.wdata;
					DLCT_OFF_IRQCFG: s_nxt.cfg_reg = s_r.wdata;
					DLCT_OFF_IRQEN: s_nxt.irq_en_reg = s_r.wdata;
					default: s_nxt.mode_reg = s_r.mode_reg;
				endcase
			end
		end

		for (int i = 0; i < NT; i++) begin
			if (ack[i]) begin
				s_nxt.flag[i] = 1'b0;
			end
			if (ovf[i]) begin
				s_nxt.flag[i] = 1'b1;
			end
		end

		// read channel
		if (s_r.rvalid && S_AXI_RREADY) begin
			s_nxt.rvalid = 1'b0;
		end
		if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd_data;
			s_nxt.rresp = rd_hit ? DLCT_RESP_OKAY : DLCT_RESP_SLVERR;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	for (genvar g = 0; g < NT; g++) begin : g_tmr
		logic [3:0] nib;
		logic pol;
		assign nib = s_r.mode_reg[DLCT_MODE_STRIDE * g +: DLCT_MODE_STRIDE];
		assign pol = s_r.cfg_reg[DLCT_POL_BIT + DLCT_POL_STRIDE * g];

		dlct_timer u_tmr (
			.clk(CORE_CLK),
			.rst_n(RST_N),
			.tick_pre(tick_pre),
			.mode(dlct_mode_t'(nib[DLCT_MODE_SEL_LSB +: 2])),
			.ct_sel(nib[DLCT_MODE_CT_BIT]),
			.sys_sel(s_r.clk_reg[DLCT_CLK_SYS_BIT + g]),
			.gate_bit(nib[DLCT_MODE_GATE_BIT]),
			.gate_act(gate_in[g] == pol),
			.run(s_r.run[g]),
			.event_pin(pins[g]),
			.wr_lo(wr_lo[g]),
			.wr_hi(wr_hi[g]),
			.wdata(s_r.wdata),
			.count_lo(cnt_lo[g]),
			.count_hi(cnt_hi[g]),
			.ovf(ovf[g])
		);
	end

	assign T0_IRQ_REQ = s_r.flag[0] & s_r.irq_en_reg[DLCT_IRQEN_BIT];
	assign T1_IRQ_REQ = s_r.flag[1] & s_r.irq_en_reg[DLCT_IRQEN_BIT + DLCT_IRQEN_STRIDE];

	// bus outputs
	assign S_AXI_BVALID = s_r.bvalid;
	assign S_AXI_BRESP = s_r.bresp;
	assign S_AXI_RVALID = s_r.rvalid;
	assign S_AXI_RRESP = s_r.rresp;
	assign S_AXI_RDATA = {24'h000000, s_r.rdata};

endmodule
`default_nettype wire

// ===== verif/dlct_chk_sva.sv
// bus and interrupt checker for the dual counter/timer
`timescale 1ns/1ns
`default_nettype none
module dlct_chk (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic T0_IRQ_ACK,
	input wire logic T0_IRQ_REQ,
	input wire logic T1_IRQ_REQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	logic wr_idle;
	// no write about to land this cycle
	assign wr_idle = S_AXI_AWREADY || S_AXI_WREADY || S_AXI_BVALID;
	sequence wr_take;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	sequence wr_reply;
		!S_AXI_BVALID ##1 S_AXI_BVALID;
	endsequence
	a_wr_reply: assert property (wr_take |=> wr_reply)
		else $error("write reply timing wrong");
	a_rd_reply: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read reply missing");
	a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
		else $error("write reply dropped");
	a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RDATA))
		else $error("read data changed");
	a_ar_block: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
		else $error("read taken while busy");
	a_rd_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h000000)
		else $error("read upper bits set");
	a_req_keep: assert property (T0_IRQ_REQ && !T0_IRQ_ACK && wr_idle |=> T0_IRQ_REQ)
		else $error("request dropped alone");
	a_req_reset: assert property ($rose(RST_N) |-> !T0_IRQ_REQ && !T1_IRQ_REQ)
		else $error("request after reset");
endmodule
bind dlct_top dlct_chk u_chk (
	.CORE_CLK(CORE_CLK),
	.RST_N(RST_N),
	.S_AXI_AWVALID(S_AXI_AWVALID),
	.S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY),
	.S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_BREADY(S_AXI_BREADY),
	.S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY),
	.S_AXI_RVALID(S_AXI_RVALID),
	.S_AXI_RREADY(S_AXI_RREADY),
	.S_AXI_RDATA(S_AXI_RDATA),
	.T0_IRQ_ACK(T0_IRQ_ACK),
	.T0_IRQ_REQ(T0_IRQ_REQ),
	.T1_IRQ_REQ(T1_IRQ_REQ)
);
`default_nettype wire

// ===== verif/dlct_pin_model.sv
// event source: falling edges at a quarter of the clock rate
`timescale 1ns/1ns
`default_nettype none
module dlct_pin_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [7:0] num,
	output logic pin,
	output logic busy
);
	logic [7:0] left_r = 8'h00;
	logic [1:0] ph_r = 2'h0;
	initial pin = 1'b1;
	assign busy = (left_r != 8'h00);
	always @(posedge clk) begin
		if (go && !busy) begin
			left_r <= num;
			ph_r <= 2'h0;
		end else if (busy) begin
			ph_r <= ph_r + 2'h1;
			pin <= ~ph_r[1];
			if (ph_r == 2'h3) begin
				left_r <= left_r - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// self-checking bench for the dual counter/timer
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module tb_top import dlct_pkg::*;;
	logic clk = 1'b0;
	logic rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic irq0, irq1, ack0, ack1, go0, go1, ev0, ev1, busy0, busy1;
	logic awready, wready, bvalid, arready, rvalid, req0, req1;
	logic [7:0] awaddr, araddr, num0, num1;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, br, rr;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	logic lazy = 1'b0;
	dlct_top u_dut (
		.CORE_CLK(clk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.T0_EVENT_PIN(ev0), .T1_EVENT_PIN(ev1),
		.EXT_IRQ0_INPUT(irq0), .EXT_IRQ1_INPUT(irq1),
		.T0_IRQ_ACK(ack0), .T1_IRQ_ACK(ack1),
		.T0_IRQ_REQ(req0), .T1_IRQ_REQ(req1)
	);
	dlct_pin_model u_pin0 (.clk(clk), .go(go0), .num(num0), .pin(ev0), .busy(busy0));
	dlct_pin_model u_pin1 (.clk(clk), .go(go1), .num(num1), .pin(ev1), .busy(busy1));
	initial forever #2 clk = ~clk;
	task automatic test_done();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= ~lazy;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		br = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= ~lazy;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rv, e)
		`CHK(rr, DLCT_RESP_OKAY)
	endtask
	task automatic wait_set(input logic [7:0] a, input int b);
		int n;
		n = 0;
		rd(a);
		while (rv[b] !== 1'b1 && n < 300) begin
			rd(a);
			n++;
		end
	endtask
	task automatic t_regs();
		rc(DLCT_OFF_CTRL, 32'h0);
		rc(DLCT_OFF_MODE, 32'h0);
		lazy = 1'b1;
		wr(8'h24, 8'h5A);
		`CHK(br, DLCT_RESP_SLVERR)
		rd(8'h24);
		`CHK(rr, DLCT_RESP_SLVERR)
		`CHK(rv, 32'h0)
		lazy = 1'b0;
	endtask
	task automatic t_gate16();
		wr(DLCT_OFF_T0_LOW, 8'hF0);
		wr(DLCT_OFF_T0_HIGH, 8'hFF);
		wr(DLCT_OFF_MODE, 8'h09);
		wr(DLCT_OFF_CLKCTL, 8'h08);
		wr(DLCT_OFF_IRQCFG, 8'h08);
		wr(DLCT_OFF_IRQEN, 8'h02);
		wr(DLCT_OFF_CTRL, 8'h10);
		rc(DLCT_OFF_T0_LOW, 32'hF0);
		rc(DLCT_OFF_T0_HIGH, 32'hFF);
		irq0 <= 1'b1;
		wait_set(DLCT_OFF_CTRL, 5);
		`CHK(rv[5], 1'b1)
		`CHK(req0, 1'b1)
		irq0 <= 1'b0;
		ack0 <= 1'b1;
		@(posedge clk);
		ack0 <= 1'b0;
		@(posedge clk);
		`CHK(req0, 1'b0)
	endtask
	task automatic t_reload();
		wr(DLCT_OFF_CTRL, 8'h00);
		rc(DLCT_OFF_CTRL, 32'h0);
		wr(DLCT_OFF_MODE, 8'h02);
		wr(DLCT_OFF_T0_HIGH, 8'hF0);
		wr(DLCT_OFF_T0_LOW, 8'hFE);
		wr(DLCT_OFF_CTRL, 8'h10);
		wait_set(DLCT_OFF_CTRL, 5);
		`CHK(rv[5], 1'b1)
		wr(DLCT_OFF_CTRL, 8'h00);
		rc(DLCT_OFF_T0_HIGH, 32'hF0);
		rd(DLCT_OFF_T0_LOW);
		`CHK(rv[7:4], 4'hF)
	endtask
	task automatic t_mode13();
		wr(DLCT_OFF_MODE, 8'h00);
		wr(DLCT_OFF_CLKCTL, 8'h10);
		wr(DLCT_OFF_T1_HIGH, 8'hFF);
		wr(DLCT_OFF_T1_LOW, 8'h1E);
		rc(DLCT_OFF_T1_LOW, 32'h1E);
		wr(DLCT_OFF_CTRL, 8'h40);
		wait_set(DLCT_OFF_CTRL, 7);
		wr(DLCT_OFF_CTRL, 8'h80);
		`CHK(rv[7], 1'b1)
		`CHK(req1, 1'b0)
		rc(DLCT_OFF_T1_HIGH, 32'h00);
	endtask
	task automatic t_count();
		wr(DLCT_OFF_CTRL, 8'h00);
		wr(DLCT_OFF_MODE, 8'h55);
		wr(DLCT_OFF_T0_LOW, 8'h00);
		wr(DLCT_OFF_T1_LOW, 8'h00);
		wr(DLCT_OFF_CTRL, 8'h50);
		num0 <= 8'h03;
		num1 <= 8'h05;
		go0 <= 1'b1;
		go1 <= 1'b1;
		@(posedge clk);
		go0 <= 1'b0;
		go1 <= 1'b0;
		@(posedge clk);
		while (busy0 || busy1) @(posedge clk);
		repeat (4) @(posedge clk);
		wr(DLCT_OFF_CTRL, 8'h00);
		rc(DLCT_OFF_T0_LOW, 32'h03);
		rc(DLCT_OFF_T1_LOW, 32'h05);
	endtask
	task automatic t_gate1();
		irq1 <= 1'b1;
		wr(DLCT_OFF_MODE, 8'h93);
		wr(DLCT_OFF_CLKCTL, 8'h18);
		wr(DLCT_OFF_IRQCFG, 8'h00);
		wr(DLCT_OFF_IRQEN, 8'h0A);
		wr(DLCT_OFF_T0_LOW, 8'h12);
		wr(DLCT_OFF_T1_HIGH, 8'hFF);
		wr(DLCT_OFF_T1_LOW, 8'hF8);
		wr(DLCT_OFF_CTRL, 8'h50);
		rc(DLCT_OFF_T1_LOW, 32'hF8);
		rc(DLCT_OFF_T0_LOW, 32'h12);
		irq1 <= 1'b0;
		wait_set(DLCT_OFF_CTRL, 7);
		`CHK(rv[7], 1'b1)
		`CHK(req1, 1'b1)
		`CHK(req0, 1'b0)
		irq1 <= 1'b1;
		ack1 <= 1'b1;
		@(posedge clk);
		ack1 <= 1'b0;
		@(posedge clk);
		`CHK(req1, 1'b0)
		wr(DLCT_OFF_CTRL, 8'h00);
	endtask
	task automatic t_scale();
		logic [5:0] divs [4];
		int lo;
		int hi;
		divs = '{DLCT_PRE_DIV0, DLCT_PRE_DIV1, DLCT_PRE_DIV2, DLCT_PRE_DIV3};
		wr(DLCT_OFF_MODE, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(DLCT_OFF_CLKCTL, 8'(k));
			wr(DLCT_OFF_T0_LOW, 8'h00);
			wr(DLCT_OFF_CTRL, 8'h10);
			repeat (200) @(posedge clk);
			wr(DLCT_OFF_CTRL, 8'h00);
			rd(DLCT_OFF_T0_LOW);
			// counting spans about 204 edges
			lo = 200 / divs[k];
			hi = 208 / divs[k] + 1;
			`CHK(rv >= lo && rv <= hi, 1'b1)
		end
	endtask
	initial begin
		{rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{irq0, irq1, ack0, ack1, go0, go1} = '0;
		{awaddr, araddr, num0, num1, wdata} = '0;
		wstrb = 4'hF;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_gate16();
		t_reload();
		t_mode13();
		t_count();
		t_gate1();
		t_scale();
		test_done();
	end
endmodule
`default_nettype wire
